// *** swc_pkg.sv ***
/*
 * swc_pkg: constants and carrier types for the sleep/wake controller.
 * Assumes a Wishbone classic slave with 32-bit data; registers are 8 bits wide,
 * one per aligned word.
 */
package swc_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_INTCTL = 8'h00; // interrupt_control
  localparam logic [7:0] ADDR_PIE = 8'h04; // peripheral_irq_enables
  localparam logic [7:0] ADDR_PIR = 8'h08; // peripheral_irq_requests
  localparam logic [7:0] ADDR_CSF = 8'h0C; // core_state_flags
  localparam logic [7:0] ADDR_WDC = 8'h10; // watchdog_control
  localparam logic [7:0] ADDR_SLP = 8'h14; // sleep status / hf keep-alive

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int INT_GIE = 7;
  localparam int INT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int INT_T0IE = 5;
  localparam int INT_EXTIE = 4;
  localparam int INT_IOCIE = 3;
  localparam int INT_T0IF = 2;
  localparam int INT_EXTIF = 1;
  localparam int INT_IOCIF = 0;
  localparam int PIR_CONV = 6;
  localparam int PIR_OSC = 4;
  localparam int PIR_LCELL = 3;
  localparam int PIR_TMR = 1;
  localparam int CSF_TO = 4;
  localparam int CSF_PD = 3;
  localparam int SLP_ASLEEP = 0;
  localparam int SLP_HFKEEP = 1;

  // ----------------------------------------------------------------------
  // masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PIR_MASK = 8'h5A;
  localparam logic [7:0] INTCTL_WMASK = 8'hFE; // ioc flag is read-only
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] PIE_RST = 8'h00;
  localparam logic [7:0] PIR_RST = 8'h00;
  localparam logic [7:0] WDC_RST = 8'h16; // 2 s period, software enable off
  localparam logic [7:0] CSF_TOPD_RST = 8'h18; // timeout_flag_n=1, power_down=1
  localparam logic [3:0] POSTSCALE_RST = 4'h0;

  // ----------------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b10
  } swc_state_type;

  // peripheral event pulses from the sleep-capable sources
  typedef struct packed {
    logic conv_done;
    logic osc_overflow;
    logic logic_cell_edge;
    logic timer_match;
  } swc_events_type;

  // reset sources seen from the pins / supervisors
  typedef struct packed {
    logic ext_pin;
    logic ext_pin_en;
    logic brownout;
    logic brownout_en;
    logic power_on;
  } swc_resets_type;

endpackage : swc_pkg

// *** swc_sync.sv ***
/*
 * swc_sync: two-flop synchroniser, one per bit.
 * Assumes asynchronous inputs and a single destination clock.
 */
`timescale 1ns/1ps
module swc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------------
  // two stages; the first is read only by the second
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule : swc_sync

// *** swc_top.sv ***
/*
 * swc_top: sleep/wake controller with its interrupt flag registers.
 * Assumes the core pulses sleep_exec_i for one cycle when it issues the
 * sleep instruction, and that a Wishbone classic master reaches the registers.
 */
// The Wishbone slave port and the address map were chosen for this implementation.
// What this block does
// - sleep is entered only when the core issues the sleep instruction
// - watchdog cleared on sleep entry; keeps counting if enabled in sleep
// - power-down flag cleared on sleep entry
// - active-low timeout flag set to one on sleep entry
// - cpu clock gated off while asleep
// - low-frequency oscillator stays running during sleep
// - converter continues in sleep when its dedicated clock is selected
// - i/o ports hold their drive state during sleep
// - non-watchdog reset sources keep working in sleep
// - wake on pin, brown-out, power-on, watchdog, external or peripheral interrupt
// - pin, brown-out and power-on wakes reset; others continue execution
// - the instruction after sleep is prefetched during sleep
// - interrupt wake needs the individual enable, not the global enable
// - global enable off resumes next instruction; on, then vectors
// - watchdog cleared on every wake-up
// - high-frequency oscillator may stay on for waveform or numeric oscillator
// - enabled flag pending before sleep makes sleep a no-operation
// - interrupt during sleep entry completes entry then wakes at once
// - request register bits 6,4,3,1 hold flags; other bits read zero
// - oscillator overflow flag set on overflow, held until cleared
// - logic-cell flag set on event, held until cleared
// - timer flag set on the match after postscaler count of matches, held until cleared
// - flags set regardless of individual or global enable
// - peripheral requests pass only while peripheral enable is set
`timescale 1ns/1ps
module swc_top (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core interface
  input wire logic sleep_exec_i,
  input wire logic clrwdt_i,
  input wire logic [3:0] timer_postscale_i,
  output logic cpu_clk_en_o,
  output logic prefetch_hold_o,
  output logic irq_vector_o,
  output logic device_reset_o,
  output logic wdt_clear_o,
  output logic asleep_o,
  // event sources
  input wire swc_pkg::swc_events_type periph_evt_i,
  input wire logic t0_ovf_i,
  input wire logic ext_int_i,
  input wire logic ioc_any_i,
  input wire logic wdt_timeout_i,
  input wire swc_pkg::swc_resets_type resets_i,
  input wire logic conv_dedicated_clk_i,
  input wire logic hf_osc_request_i,
  // clock and port controls
  output logic lf_osc_en_o,
  output logic hf_osc_en_o,
  output logic conv_clk_en_o,
  output logic port_hold_o,
  output logic [4:0] wdt_period_sel_o,
  output logic wdt_sw_enable_o
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  swc_pkg::swc_state_type state_q;
  logic [7:0] intctl_q;
  logic [7:0] pie_q;
  logic [7:0] pir_q;
  logic [7:0] wdc_q;
  logic power_down_flag_q;
  logic timeout_flag_n_q;
  logic [3:0] tmr_cnt_q;
  logic [7:0] evt_sync;
  swc_pkg::swc_resets_type rst_sync;
  logic [7:0] evt_q;
  logic [7:0] evt_rise;
  logic wb_req;
  logic wb_wr;
  logic wb_ack_q;
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  logic [7:0] pir_set;
  logic [7:0] intctl_set;
  logic periph_wake;
  logic core_wake;
  logic irq_wake;
  logic hard_reset;
  logic wdt_wake;
  logic sleep_nop;
  logic sleep_enter;
  logic tmr_fire;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // every event and reset source passes two flops before use
  swc_sync #(.WIDTH(8)) u_evt_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({periph_evt_i, t0_ovf_i, ext_int_i, ioc_any_i, wdt_timeout_i}),
    .q_o(evt_sync)
  );

  swc_sync #(.WIDTH(5)) u_rst_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(resets_i),
    .q_o(rst_sync)
  );

  // edge detect on synchronised event levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= 8'h00;
    end else if (ce_i) begin
      evt_q <= evt_sync;
    end
  end
  // watchdog timeout is a level and passes through; ioc is read from evt_sync
  assign evt_rise = {evt_sync[7:1] & ~evt_q[7:1], evt_sync[0]};

  // ----------------------------------------------------------------------
  // timer postscaler
  // ----------------------------------------------------------------------
  // counts matches; flag fires on the next match once count equals postscale setting
  assign tmr_fire = evt_rise[4] && (tmr_cnt_q == timer_postscale_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_cnt_q <= swc_pkg::POSTSCALE_RST;
    end else if (ce_i && evt_rise[4]) begin
      tmr_cnt_q <= tmr_fire ? swc_pkg::POSTSCALE_RST : tmr_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  // ----------------------------------------------------------------------
  // flag set terms
  // ----------------------------------------------------------------------
  // flags are set regardless of any enable bit
  always_comb begin
    pir_set = 8'h00;
    pir_set[swc_pkg::PIR_CONV] = evt_rise[7];
    pir_set[swc_pkg::PIR_OSC] = evt_rise[6];
    pir_set[swc_pkg::PIR_LCELL] = evt_rise[5];
    pir_set[swc_pkg::PIR_TMR] = tmr_fire;
    intctl_set = 8'h00;
    intctl_set[swc_pkg::INT_T0IF] = evt_rise[3];
    intctl_set[swc_pkg::INT_EXTIF] = evt_rise[2];
  end

  // peripheral request register; set wins over a same-cycle write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pir_q <= swc_pkg::PIR_RST;
    end else if (ce_i) begin
      if (wb_wr && wb_adr_i == swc_pkg::ADDR_PIR) begin
        pir_q <= (wb_dat_i[7:0] | pir_set) & swc_pkg::PIR_MASK;
      end else begin
        pir_q <= pir_q | pir_set;
      end
    end
  end

  // interrupt control; ioc flag follows its source level, read-only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intctl_q <= swc_pkg::INTCTL_RST;
    end else if (ce_i) begin
      if (wb_wr && wb_adr_i == swc_pkg::ADDR_INTCTL) begin
        intctl_q <= (wb_dat_i[7:0] & swc_pkg::INTCTL_WMASK) | intctl_set | {7'h00, evt_sync[1]};
      end else begin
        intctl_q <= {intctl_q[7:1] | intctl_set[7:1], evt_sync[1]};
      end
    end
  end

  // enable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pie_q <= swc_pkg::PIE_RST;
      wdc_q <= swc_pkg::WDC_RST;
    end else if (ce_i && wb_wr) begin
      if (wb_adr_i == swc_pkg::ADDR_PIE) begin
        pie_q <= wb_dat_i[7:0] & swc_pkg::PIR_MASK;
      end
      if (wb_adr_i == swc_pkg::ADDR_WDC) begin
        wdc_q <= {2'b00, wb_dat_i[5:0]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // wake request
  // ----------------------------------------------------------------------
  // individual enables, plus peripheral enable for peripheral flags; global enable does not gate wake
  assign periph_wake = |(pir_q & pie_q) && intctl_q[swc_pkg::INT_PERIPHERAL_IRQ_ENABLE];
  assign core_wake = (intctl_q[swc_pkg::INT_T0IE] && intctl_q[swc_pkg::INT_T0IF])
    || (intctl_q[swc_pkg::INT_EXTIE] && intctl_q[swc_pkg::INT_EXTIF])
    || (intctl_q[swc_pkg::INT_IOCIE] && intctl_q[swc_pkg::INT_IOCIF]);
  assign irq_wake = periph_wake || core_wake;
  // pin and brown-out reset only when enabled; power-on always
  assign hard_reset = (rst_sync.ext_pin && rst_sync.ext_pin_en)
    || (rst_sync.brownout && rst_sync.brownout_en) || rst_sync.power_on;
  assign wdt_wake = evt_sync[0];

  // pending enabled flag before sleep turns it into a no-operation
  assign sleep_nop = sleep_exec_i && state_q == swc_pkg::ST_RUN && irq_wake;
  assign sleep_enter = sleep_exec_i && state_q == swc_pkg::ST_RUN && !irq_wake;

  // ----------------------------------------------------------------------
  // sleep state machine
  // ----------------------------------------------------------------------
  // ST_WAKE lasts one cycle so the resume/vector decision is a clean pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= swc_pkg::ST_RUN;
    end else if (ce_i) begin
      case (state_q)
        swc_pkg::ST_RUN: begin
          if (sleep_enter) begin
            state_q <= swc_pkg::ST_SLEEP;
          end
        end
        swc_pkg::ST_SLEEP: begin
          // a request arriving during entry wakes on the next cycle
          if (irq_wake || wdt_wake || hard_reset) begin
            state_q <= swc_pkg::ST_WAKE;
          end
        end
        swc_pkg::ST_WAKE: begin
          state_q <= swc_pkg::ST_RUN;
        end
        default: begin
          state_q <= swc_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  // no-op sleep leaves both flags untouched; watchdog wake clears the
  // timeout flag so software can tell why it woke
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_down_flag_q <= swc_pkg::CSF_TOPD_RST[swc_pkg::CSF_PD];
      timeout_flag_n_q <= swc_pkg::CSF_TOPD_RST[swc_pkg::CSF_TO];
    end else if (ce_i) begin
      if (sleep_enter) begin
        power_down_flag_q <= 1'b0;
        timeout_flag_n_q <= 1'b1;
      end else if (state_q == swc_pkg::ST_SLEEP && wdt_wake && !irq_wake) begin
        timeout_flag_n_q <= 1'b0;
      end else if (clrwdt_i && state_q == swc_pkg::ST_RUN) begin
        power_down_flag_q <= 1'b1;
        timeout_flag_n_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // core and clock controls
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_vector_o <= 1'b0;
      device_reset_o <= 1'b0;
      wdt_clear_o <= 1'b0;
    end else if (ce_i) begin
      // vector only after the prefetched instruction runs, when global is on
      irq_vector_o <= state_q == swc_pkg::ST_WAKE && irq_wake
        && intctl_q[swc_pkg::INT_GIE];
      device_reset_o <= state_q == swc_pkg::ST_SLEEP && hard_reset;
      // cleared on entry and on every exit, not on a no-op sleep
      wdt_clear_o <= sleep_enter || clrwdt_i
        || (state_q == swc_pkg::ST_SLEEP && (irq_wake || wdt_wake || hard_reset));
    end
  end

  assign asleep_o = state_q == swc_pkg::ST_SLEEP;
  assign cpu_clk_en_o = !asleep_o;
  // the prefetched instruction is frozen, not refetched
  assign prefetch_hold_o = asleep_o;
  assign port_hold_o = asleep_o;
  assign lf_osc_en_o = 1'b1;
  assign hf_osc_en_o = !asleep_o || hf_osc_request_i;
  assign conv_clk_en_o = !asleep_o || conv_dedicated_clk_i;
  // watchdog keeps counting in sleep when enabled; counter lives outside
  assign wdt_period_sel_o = wdc_q[5:1];
  assign wdt_sw_enable_o = wdc_q[0];

  // ----------------------------------------------------------------------
  // read mux and ack
  // ----------------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      swc_pkg::ADDR_INTCTL: rd_d[7:0] = intctl_q;
      swc_pkg::ADDR_PIE: rd_d[7:0] = pie_q;
      swc_pkg::ADDR_PIR: rd_d[7:0] = pir_q & swc_pkg::PIR_MASK;
      swc_pkg::ADDR_CSF: begin
        rd_d[swc_pkg::CSF_TO] = timeout_flag_n_q;
        rd_d[swc_pkg::CSF_PD] = power_down_flag_q;
      end
      swc_pkg::ADDR_WDC: rd_d[7:0] = wdc_q;
      swc_pkg::ADDR_SLP: begin
        rd_d[swc_pkg::SLP_ASLEEP] = asleep_o;
        rd_d[swc_pkg::SLP_HFKEEP] = hf_osc_request_i;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // one wait-free ack per request; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_q <= wb_req;
      if (wb_req) begin
        rd_q <= rd_d;
      end
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = rd_q;

endmodule : swc_top

// *** swc_monitor.sv ***
/*
 * swc_monitor: timing and relation checks on the sleep/wake controller ports.
 * Assumes one clock, sync active-high reset, bound onto swc_top.
 */
`timescale 1ns/1ps
module swc_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // core and sources
  input wire logic sleep_exec_i,
  input wire logic wdt_timeout_i,
  input wire logic cpu_clk_en_o,
  input wire logic asleep_o,
  input wire logic port_hold_o,
  input wire logic prefetch_hold_o,
  input wire logic lf_osc_en_o,
  input wire logic wdt_clear_o,
  input wire logic irq_vector_o,
  input wire logic device_reset_o
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_bus_answer: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_entry_cause: assert property ($rose(asleep_o) |-> $past(sleep_exec_i))
    else $error("sleep entered without sleep instruction");
  a_entry_clear: assert property ($rose(asleep_o) |-> wdt_clear_o)
    else $error("watchdog not cleared on sleep entry");
  a_clk_stopped: assert property (asleep_o |-> !cpu_clk_en_o)
    else $error("cpu clock running while asleep");
  a_lf_running: assert property (lf_osc_en_o)
    else $error("low-frequency oscillator stopped");
  a_hold_state: assert property (port_hold_o == asleep_o && prefetch_hold_o == asleep_o)
    else $error("port or prefetch hold not tracking sleep");
  a_wake_clear: assert property ($fell(asleep_o) |-> wdt_clear_o)
    else $error("watchdog not cleared on wake");
  a_wdt_wake: assert property (asleep_o && wdt_timeout_i |-> ##[1:6] !asleep_o)
    else $error("watchdog timeout did not wake");
  a_reset_wake: assert property (device_reset_o |-> $past(asleep_o))
    else $error("device reset pulse outside a wake");
  a_vector_late: assert property (irq_vector_o |-> $past(asleep_o, 2) && cpu_clk_en_o)
    else $error("vector pulse not two cycles after sleep");

  // main scenarios reached
  c_sleep: cover property ($rose(asleep_o));
  c_vector: cover property (irq_vector_o);
  c_hard: cover property (device_reset_o);
endmodule : swc_monitor

bind swc_top swc_monitor swc_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .sleep_exec_i(sleep_exec_i), .wdt_timeout_i(wdt_timeout_i),
  .cpu_clk_en_o(cpu_clk_en_o), .asleep_o(asleep_o), .port_hold_o(port_hold_o),
  .prefetch_hold_o(prefetch_hold_o), .lf_osc_en_o(lf_osc_en_o),
  .wdt_clear_o(wdt_clear_o), .irq_vector_o(irq_vector_o),
  .device_reset_o(device_reset_o));

// *** swc_core_model.sv ***
/*
 * swc_core_model: behavioural core sequencer facing the controller.
 * Assumes the same clock; the bench calls issue_sleep hierarchically.
 */
`timescale 1ns/1ps
module swc_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // controller side
  input wire logic cpu_clk_en_i,
  output logic sleep_exec_o,
  output logic [15:0] pc_o
);
  initial sleep_exec_o = 1'b0;

  // program counter moves only on enabled cycles, so a stall is visible
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= 16'h0000;
    end else if (cpu_clk_en_i) begin
      pc_o <= pc_o + 16'h0001;
    end
  end

  // one-cycle sleep pulse; the slot after it is treated as a nop
  task automatic issue_sleep();
    @(posedge clk_i);
    sleep_exec_o <= 1'b1;
    @(posedge clk_i);
    sleep_exec_o <= 1'b0;
  endtask : issue_sleep
endmodule : swc_core_model

// *** tb_swc_top.sv ***
/*
 * tb_swc_top: register, flag, sleep and wake sequences for swc_top.
 * Assumes swc_core_model as core and the bound swc_monitor.
 */
`timescale 1ns/1ps
module tb_swc_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, clrwdt = 1'b0, ext_int = 1'b0;
  logic wdt_to = 1'b0, conv_clk = 1'b0, sleep_exec, cpu_en, pf, vec, drst, wclr;
  logic asleep, lf, hf, conv_en, ph, wsw;
  logic hf_req = 1'b0, ioc = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] post = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o, rd;
  logic [4:0] wps;
  logic [15:0] pc, pc_mark;
  swc_pkg::swc_events_type evt = 4'h0;
  swc_pkg::swc_resets_type rs = 5'h00;
  int err_count = 0, cmp_count = 0, vec_n = 0, drst_n = 0;

  swc_top swc_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .sleep_exec_i(sleep_exec), .clrwdt_i(clrwdt),
    .timer_postscale_i(post), .cpu_clk_en_o(cpu_en), .prefetch_hold_o(pf),
    .irq_vector_o(vec), .device_reset_o(drst), .wdt_clear_o(wclr), .asleep_o(asleep),
    .periph_evt_i(evt), .t0_ovf_i(1'b0), .ext_int_i(ext_int), .ioc_any_i(ioc),
    .wdt_timeout_i(wdt_to), .resets_i(rs), .conv_dedicated_clk_i(conv_clk),
    .hf_osc_request_i(hf_req), .lf_osc_en_o(lf), .hf_osc_en_o(hf),
    .conv_clk_en_o(conv_en), .port_hold_o(ph), .wdt_period_sel_o(wps),
    .wdt_sw_enable_o(wsw));
  swc_core_model swc_core_model_i (.clk_i(clk_i), .rst_i(rst_i), .cpu_clk_en_i(cpu_en),
    .sleep_exec_o(sleep_exec), .pc_o(pc));

  // ----------------------------------------------------------------------
  // clock, pulse counters, tasks
  // ----------------------------------------------------------------------
  always #5 clk_i = ~clk_i;
  // pulses last one cycle, so count them at every edge
  always @(posedge clk_i) begin
    if (vec === 1'b1) vec_n++;
    if (drst === 1'b1) drst_n++;
  end

  task automatic close_out();
    $display("compared %0d mismatched %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask : chk_bit
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  // classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) begin
      err_count++;
      close_out();
    end
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0000_0000);
    chk_reg(rd, e);
  endtask : rdc
  task automatic ev(input int b);
    @(posedge clk_i);
    evt[b] <= 1'b1;
    idle(3);
    evt[b] <= 1'b0;
    idle(4);
  endtask : ev
  task automatic wait_st(input logic s);
    int n;
    n = 0;
    while (asleep !== s && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      close_out();
    end else begin
      chk_bit(asleep, s);
    end
  endtask : wait_st

  // ----------------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------------
  initial begin
    idle(8);
    rst_i <= 1'b0;
    // reset values, unmapped place, watchdog fields
    rdc(swc_pkg::ADDR_INTCTL, 32'h00);
    rdc(swc_pkg::ADDR_PIE, 32'h00);
    rdc(swc_pkg::ADDR_CSF, {24'h0, swc_pkg::CSF_TOPD_RST});
    rdc(swc_pkg::ADDR_WDC, {24'h0, swc_pkg::WDC_RST});
    wb(8'h1C, 1'b1, 32'hFF);
    rdc(8'h1C, 32'h00);
    wb(swc_pkg::ADDR_WDC, 1'b1, 32'h23);
    chk_reg({26'h0, wps, wsw}, 32'h23);
    $display("test registers done");
    // flag register layout and setting with enables off
    wb(swc_pkg::ADDR_PIR, 1'b1, 32'hFF);
    rdc(swc_pkg::ADDR_PIR, 32'h5A);
    wb(swc_pkg::ADDR_PIR, 1'b1, 32'h00);
    ev(1);
    rdc(swc_pkg::ADDR_PIR, 32'h08);
    ev(2);
    rdc(swc_pkg::ADDR_PIR, 32'h18);
    ev(3);
    rdc(swc_pkg::ADDR_PIR, 32'h58);
    post <= 4'h2;
    ev(0);
    ev(0);
    rdc(swc_pkg::ADDR_PIR, 32'h58);
    ev(0);
    rdc(swc_pkg::ADDR_PIR, 32'h5A);
    wb(swc_pkg::ADDR_PIR, 1'b1, 32'h00);
    $display("test flags done");
    // sleep entry, then wake needs both enables
    conv_clk <= 1'b1;
    swc_core_model_i.issue_sleep();
    wait_st(1'b1);
    chk_bit(cpu_en, 1'b0);
    chk_bit(conv_en, 1'b1);
    chk_bit(hf, 1'b0);
    rdc(swc_pkg::ADDR_CSF, 32'h10);
    hf_req <= 1'b1;
    rdc(swc_pkg::ADDR_SLP, 32'h3);
    chk_bit(hf, 1'b1);
    hf_req <= 1'b0;
    pc_mark = pc;
    ev(2);
    wb(swc_pkg::ADDR_INTCTL, 1'b1, 32'h40);
    idle(6);
    chk_bit(asleep, 1'b1);
    wb(swc_pkg::ADDR_INTCTL, 1'b1, 32'h00);
    wb(swc_pkg::ADDR_PIE, 1'b1, 32'h10);
    idle(6);
    chk_bit(asleep, 1'b1);
    chk_reg({16'h0, pc}, {16'h0, pc_mark});
    wb(swc_pkg::ADDR_INTCTL, 1'b1, 32'h40);
    wait_st(1'b0);
    idle(4);
    chk_reg(32'(vec_n), 32'h0);
    $display("test peripheral wake done");
    // pending enabled flag before sleep
    clrwdt <= 1'b1;
    idle(1);
    clrwdt <= 1'b0;
    swc_core_model_i.issue_sleep();
    idle(4);
    chk_bit(asleep, 1'b0);
    rdc(swc_pkg::ADDR_CSF, 32'h18);
    wb(swc_pkg::ADDR_PIR, 1'b1, 32'h00);
    wb(swc_pkg::ADDR_PIE, 1'b1, 32'h00);
    // interrupt arriving during entry, then global-enable wake
    wb(swc_pkg::ADDR_INTCTL, 1'b1, 32'h10);
    ext_int <= 1'b1;
    swc_core_model_i.issue_sleep();
    idle(8);
    chk_bit(asleep, 1'b0);
    rdc(swc_pkg::ADDR_CSF, 32'h10);
    ext_int <= 1'b0;
    wb(swc_pkg::ADDR_INTCTL, 1'b1, 32'h90);
    swc_core_model_i.issue_sleep();
    wait_st(1'b1);
    ext_int <= 1'b1;
    wait_st(1'b0);
    idle(4);
    chk_reg(32'(vec_n), 32'h1);
    ext_int <= 1'b0;
    wb(swc_pkg::ADDR_INTCTL, 1'b1, 32'h00);
    // interrupt-on-change level wakes with its own enable only
    wb(swc_pkg::ADDR_INTCTL, 1'b1, 32'h08);
    swc_core_model_i.issue_sleep();
    wait_st(1'b1);
    ioc <= 1'b1;
    wait_st(1'b0);
    rdc(swc_pkg::ADDR_INTCTL, 32'h09);
    ioc <= 1'b0;
    wb(swc_pkg::ADDR_INTCTL, 1'b1, 32'h00);
    $display("test interrupt wake done");
    // hard reset wake, then watchdog wake
    swc_core_model_i.issue_sleep();
    wait_st(1'b1);
    rs.power_on <= 1'b1;
    wait_st(1'b0);
    idle(3);
    chk_reg(32'(drst_n), 32'h1);
    rs.power_on <= 1'b0;
    idle(6);
    swc_core_model_i.issue_sleep();
    wait_st(1'b1);
    wdt_to <= 1'b1;
    wait_st(1'b0);
    wdt_to <= 1'b0;
    rdc(swc_pkg::ADDR_CSF, 32'h00);
    chk_reg(32'(drst_n), 32'h1);
    $display("test reset wake done");
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    rdc(swc_pkg::ADDR_CSF, {24'h0, swc_pkg::CSF_TOPD_RST});
    close_out();
  end
endmodule : tb_swc_top
